/* asfl_pkg.sv */
// asfl_pkg: shared constants and types for the ALU and flag register
package asfl_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_WORK = 8'h04;
  localparam logic [7:0] ADDR_FILE = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;

  // ------------------------------------------------------------------
  // flag register fields and reset values
  // ------------------------------------------------------------------
  localparam int CARRY_BIT = 0;
  localparam int DIGIT_CARRY_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam int OVERFLOW_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam logic [7:0] FLAGS_RESET = 8'hF0;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;

  // ------------------------------------------------------------------
  // command word fields
  // ------------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int SRC_FILE_BIT = 5;
  localparam int USE_IMM_BIT = 6;
  localparam int DST_FILE_BIT = 8;
  localparam int TGT_FLAGS_BIT = 9;
  localparam int BITSEL_LSB = 10;
  localparam int IMM_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC, OP_NEG,
    OP_AND, OP_IOR, OP_XOR, OP_COM, OP_CLR, OP_MOVF,
    OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_SWAP, OP_MOVE_FROM_WORKING_INSTRUCTION, OP_BCF, OP_BSF
  } op_type;
  localparam logic [4:0] OP_COUNT = 5'h15;

  typedef enum logic [2:0] {
    SEL_FLAGS, SEL_WORK, SEL_FILE, SEL_CMD, SEL_RESULT, SEL_NONE
  } reg_sel_type;

  typedef struct packed {
    op_type op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
    logic [2:0] bit_sel;
  } alu_in_type;

  // flags and mask are ordered {overflow, zero, digit carry, carry}
  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flags;
    logic [3:0] mask;
  } alu_out_type;

endpackage

/* asfl_alu_core.sv */
// asfl_alu_core: combinational 8-bit ALU with flag generation
`timescale 1ns/1ps
module asfl_alu_core (
  input wire asfl_pkg::alu_in_type alu_in,
  output asfl_pkg::alu_out_type alu_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] x;
  logic [7:0] y;
  logic ci;
  logic arith;
  logic [7:0] one_hot;

  // ------------------------------------------------------------------
  // adder operand selection
  // ------------------------------------------------------------------
  always_comb begin
    x = alu_in.b;
    y = alu_in.a;
    ci = 1'b0;
    arith = 1'b1;
    case (alu_in.op)
      asfl_pkg::OP_ADD: ci = 1'b0;
      asfl_pkg::OP_ADDC: ci = alu_in.carry_in;
      // subtract as b + ~a + 1, carry means no borrow
      asfl_pkg::OP_SUB: begin
        y = ~alu_in.a;
        ci = 1'b1;
      end
      asfl_pkg::OP_SUBB: begin
        y = ~alu_in.a;
        ci = alu_in.carry_in;
      end
      asfl_pkg::OP_INC: begin
        y = 8'h00;
        ci = 1'b1;
      end
      asfl_pkg::OP_DEC: y = 8'hFF;
      asfl_pkg::OP_NEG: begin
        x = 8'h00;
        y = ~alu_in.b;
        ci = 1'b1;
      end
      default: arith = 1'b0;
    endcase
    sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
  end

  // ------------------------------------------------------------------
  // result and flags
  // ------------------------------------------------------------------
  always_comb begin
    one_hot = 8'h01 << alu_in.bit_sel;
    alu_out.res = alu_in.b;
    alu_out.flags = 4'h0;
    alu_out.mask = 4'h0;
    if (arith) begin
      alu_out.res = sum[7:0];
      alu_out.mask = 4'hF;
      alu_out.flags[asfl_pkg::CARRY_BIT] = sum[8];
      alu_out.flags[asfl_pkg::DIGIT_CARRY_BIT] = nib[4];
      // sign change from like-signed inputs
      alu_out.flags[asfl_pkg::OVERFLOW_BIT] =
        (x[7] == y[7]) && (sum[7] != x[7]);
    end else begin
      case (alu_in.op)
        asfl_pkg::OP_AND: alu_out.res = alu_in.a & alu_in.b;
        asfl_pkg::OP_IOR: alu_out.res = alu_in.a | alu_in.b;
        asfl_pkg::OP_XOR: alu_out.res = alu_in.a ^ alu_in.b;
        asfl_pkg::OP_COM: alu_out.res = ~alu_in.b;
        asfl_pkg::OP_CLR: alu_out.res = 8'h00;
        asfl_pkg::OP_MOVF: alu_out.res = alu_in.b;
        // carry takes the bit shifted out
        asfl_pkg::OP_RLC: begin
          alu_out.res = {alu_in.b[6:0], alu_in.carry_in};
          alu_out.flags[asfl_pkg::CARRY_BIT] = alu_in.b[7];
        end
        asfl_pkg::OP_RRC: begin
          alu_out.res = {alu_in.carry_in, alu_in.b[7:1]};
          alu_out.flags[asfl_pkg::CARRY_BIT] = alu_in.b[0];
        end
        asfl_pkg::OP_RLN: alu_out.res = {alu_in.b[6:0], alu_in.b[7]};
        asfl_pkg::OP_RRN: alu_out.res = {alu_in.b[0], alu_in.b[7:1]};
        // these four leave every flag alone
        asfl_pkg::OP_SWAP: alu_out.res = {alu_in.b[3:0], alu_in.b[7:4]};
        asfl_pkg::OP_MOVE_FROM_WORKING_INSTRUCTION: alu_out.res = alu_in.a;
        asfl_pkg::OP_BCF: alu_out.res = alu_in.b & ~one_hot;
        asfl_pkg::OP_BSF: alu_out.res = alu_in.b | one_hot;
        default: alu_out.res = alu_in.b;
      endcase
      case (alu_in.op)
        asfl_pkg::OP_AND, asfl_pkg::OP_IOR, asfl_pkg::OP_XOR,
        asfl_pkg::OP_COM, asfl_pkg::OP_CLR, asfl_pkg::OP_MOVF:
          alu_out.mask[asfl_pkg::ZERO_BIT] = 1'b1;
        asfl_pkg::OP_RLC, asfl_pkg::OP_RRC:
          alu_out.mask[asfl_pkg::CARRY_BIT] = 1'b1;
        default: alu_out.mask = 4'h0;
      endcase
    end
    alu_out.flags[asfl_pkg::ZERO_BIT] = (alu_out.res == 8'h00);
  end

endmodule

/* asfl_top.sv */
// asfl_top: ALU with flag register behind an AXI4-Lite slave
//
// How it works
// - each command runs one arithmetic or logic op on one or two operands.
// - a single-operand op works on the working register or the file reg.
// - a two-operand op uses the working register and a file reg or immed.
// - the flag register holds the four flags and the pointer mode bits.
// - the flag register may be the destination of any command.
// - when a flag-changing op writes the flag reg, flag logic wins.
// - clearing the flag register zeroes the mode bits and sets zero.
// - bit clear, bit set, nibble swap and move-from-W change no flag.
// - in subtraction carry and digit carry act as inverted borrows.
// - overflow is set when the signed result leaves -128..+127.
// - zero flag (bit 2) is set exactly when the result is zero, except for rotates, swap, bit ops and move-from-W, which leave it.
// - overflow flag (bit 3) marks a signed change of the sign bit.
// - rotate through carry loads carry with the bit shifted out.
// - subtraction adds the two's complement of the working register.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module asfl_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] alu_flags_and_pointer_mode,
  output logic [7:0] working_register
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // only the word address counts; byte offset bits are ignored
  function automatic asfl_pkg::reg_sel_type decode_addr(
    input logic [ADDR_W-1:0] addr
  );
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    if (word == asfl_pkg::ADDR_FLAGS) begin
      return asfl_pkg::SEL_FLAGS;
    end else if (word == asfl_pkg::ADDR_WORK) begin
      return asfl_pkg::SEL_WORK;
    end else if (word == asfl_pkg::ADDR_FILE) begin
      return asfl_pkg::SEL_FILE;
    end else if (word == asfl_pkg::ADDR_CMD) begin
      return asfl_pkg::SEL_CMD;
    end else if (word == asfl_pkg::ADDR_RESULT) begin
      return asfl_pkg::SEL_RESULT;
    end else begin
      return asfl_pkg::SEL_NONE;
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic aw_held_reg, aw_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic [7:0] flags_reg, flags_next;
  logic [7:0] work_reg, work_next;
  logic [7:0] file_reg, file_next;
  logic [7:0] result_reg, result_next;
  logic [31:0] cmd_reg, cmd_next;

  logic write_go;
  logic write_ok;
  asfl_pkg::reg_sel_type wsel;
  asfl_pkg::reg_sel_type rsel;

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  logic [4:0] op_code;
  logic op_legal;
  logic two_operand;
  logic tgt_flags;
  logic writes_file;
  logic [7:0] imm_val;
  logic [7:0] file_val;
  logic [3:0] merged_flags;
  asfl_pkg::alu_in_type alu_in;
  asfl_pkg::alu_out_type alu_out;

  assign write_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wsel = decode_addr(awaddr_reg);
  assign rsel = decode_addr(s_axi_araddr);

  always_comb begin
    op_code = wdata_reg[asfl_pkg::OP_LSB +: 5];
    op_legal = op_code < asfl_pkg::OP_COUNT;
    tgt_flags = wdata_reg[asfl_pkg::TGT_FLAGS_BIT];
    imm_val = wstrb_reg[2] ? wdata_reg[asfl_pkg::IMM_LSB +: 8] : 8'h00;
    // the flag register is reachable as a file operand
    file_val = tgt_flags ? flags_reg : file_reg;
    alu_in.op = asfl_pkg::op_type'(op_code);
    alu_in.carry_in = flags_reg[asfl_pkg::CARRY_BIT];
    alu_in.bit_sel = wdata_reg[asfl_pkg::BITSEL_LSB +: 3];
    alu_in.a = work_reg;
    two_operand = 1'b0;
    case (alu_in.op)
      asfl_pkg::OP_ADD, asfl_pkg::OP_ADDC, asfl_pkg::OP_SUB,
      asfl_pkg::OP_SUBB, asfl_pkg::OP_AND, asfl_pkg::OP_IOR,
      asfl_pkg::OP_XOR, asfl_pkg::OP_MOVE_FROM_WORKING_INSTRUCTION:
        two_operand = 1'b1;
      default: two_operand = 1'b0;
    endcase
    if (two_operand) begin
      // second operand: file register or 8-bit immediate
      alu_in.b = wdata_reg[asfl_pkg::USE_IMM_BIT] ? imm_val : file_val;
    end else begin
      // lone operand: working register or file register
      alu_in.b = wdata_reg[asfl_pkg::SRC_FILE_BIT] ? file_val : work_reg;
    end
    case (alu_in.op)
      asfl_pkg::OP_MOVE_FROM_WORKING_INSTRUCTION, asfl_pkg::OP_BCF, asfl_pkg::OP_BSF:
        writes_file = 1'b1;
      default: writes_file = wdata_reg[asfl_pkg::DST_FILE_BIT];
    endcase
    // flag bits touched by the op come from flag logic
    merged_flags = (alu_out.flags & alu_out.mask) |
                   (flags_reg[3:0] & ~alu_out.mask);
  end

  asfl_alu_core u_alu (
    .alu_in(alu_in),
    .alu_out(alu_out)
  );

  // ------------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------------
  // aw and w are taken in either order and held until both are in
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    write_ok = 1'b1;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (write_go) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      if (wsel == asfl_pkg::SEL_NONE) begin
        write_ok = 1'b0;
      end else if (wsel == asfl_pkg::SEL_CMD) begin
        write_ok = op_legal;
      end
      bresp_next = write_ok ? asfl_pkg::RESP_OKAY : asfl_pkg::RESP_SLVERR;
    end
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
  end

  // ------------------------------------------------------------------
  // register file and execution
  // ------------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    work_next = work_reg;
    file_next = file_reg;
    result_next = result_reg;
    cmd_next = cmd_reg;
    if (write_go && wstrb_reg[0]) begin
      case (wsel)
        // plain register write; the four flag bits are writable here
        asfl_pkg::SEL_FLAGS: flags_next = wdata_reg[7:0];
        asfl_pkg::SEL_WORK: work_next = wdata_reg[7:0];
        asfl_pkg::SEL_FILE: file_next = wdata_reg[7:0];
        asfl_pkg::SEL_CMD: begin
          if (op_legal) begin
            // one op per command, result to W or a file
            cmd_next = wdata_reg;
            result_next = alu_out.res;
            if (writes_file && tgt_flags) begin
              if (alu_out.mask != 4'h0) begin
                // clear gives 0000 in the mode bits, zero set
                flags_next = {alu_out.res[7:4], merged_flags};
              end else begin
                // non-flag ops store the full byte
                flags_next = alu_out.res;
              end
            end else begin
              flags_next[3:0] = merged_flags;
              if (writes_file) begin
                file_next = alu_out.res;
              end else begin
                work_next = alu_out.res;
              end
            end
          end
        end
        default: result_next = result_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  // read data is sampled at the address handshake; no wait states
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = asfl_pkg::RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (rsel)
        asfl_pkg::SEL_FLAGS: rdata_next[7:0] = flags_reg;
        asfl_pkg::SEL_WORK: rdata_next[7:0] = work_reg;
        asfl_pkg::SEL_FILE: rdata_next[7:0] = file_reg;
        asfl_pkg::SEL_CMD: rdata_next = cmd_reg;
        asfl_pkg::SEL_RESULT: rdata_next[7:0] = result_reg;
        default: rresp_next = asfl_pkg::RESP_SLVERR;
      endcase
    end
    arready_next = !rvalid_next;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= asfl_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= asfl_pkg::RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= asfl_pkg::FLAGS_RESET;
      work_reg <= asfl_pkg::WORK_RESET;
      file_reg <= asfl_pkg::FILE_RESET;
      result_reg <= 8'h00;
      cmd_reg <= 32'h0000_0000;
    end else begin
      flags_reg <= flags_next;
      work_reg <= work_next;
      file_reg <= file_next;
      result_reg <= result_next;
      cmd_reg <= cmd_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign alu_flags_and_pointer_mode = flags_reg;
  assign working_register = work_reg;

endmodule

/* asfl_asserts.sv */
// asfl_asserts: bus and flag register checks for asfl_top
`timescale 1ns/1ps
module asfl_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] alu_flags_and_pointer_mode,
  input wire logic [7:0] working_register
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_vals: assert property ($past(reset) |->
    alu_flags_and_pointer_mode == 8'hF0 && working_register == 8'h00)
    else $error("reset values wrong");
  a_flag_commit: assert property ($changed(alu_flags_and_pointer_mode)
    |-> $rose(s_axi_bvalid)) else $error("flags moved off commit");
  a_work_commit: assert property ($changed(working_register)
    |-> $rose(s_axi_bvalid)) else $error("work reg moved off commit");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
    s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready stayed high");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_flags: cover property ($changed(alu_flags_and_pointer_mode));
endmodule

bind asfl_top asfl_asserts #(.ADDR_W(ADDR_W)) asfl_asserts_inst (.*);

/* asfl_host.sv */
// asfl_host: bus master standing in for the core's decode and sequencing
`timescale 1ns/1ps
module asfl_host (
  input wire logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // ----
  // bus cycles
  // ----
  // address and data offered together, each dropped at its own take
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* tb.sv */
// tb: self-checking bench for the ALU and flag register
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0] alu_flags_and_pointer_mode, working_register;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  typedef struct packed {
    logic [31:0] cmd;
    logic [7:0] w, f, res;
    logic [3:0] fl;
  } asfl_row_type;
  // flags preset to F0 before each row, so unaffected flags read 0
  asfl_row_type rows [20] = '{
    '{32'h00, 8'h7F, 8'h01, 8'h80, 4'hA},
    '{32'h02, 8'h05, 8'h05, 8'h00, 4'h7},
    '{32'h02, 8'h01, 8'h00, 8'hFF, 4'h0},
    '{32'h02, 8'h01, 8'h80, 8'h7F, 4'h9},
    '{32'h00, 8'h08, 8'h08, 8'h10, 4'h2},
    '{32'h000F0047, 8'hF0, 8'h00, 8'h00, 4'h4},
    '{32'h2D, 8'h00, 8'h80, 8'h00, 4'h1},
    '{32'h2E, 8'h00, 8'h01, 8'h00, 4'h1},
    '{32'h31, 8'h00, 8'h5A, 8'hA5, 4'h0},
    '{32'h24, 8'h00, 8'hFF, 8'h00, 4'h7},
    '{32'h01, 8'hFF, 8'h01, 8'h00, 4'h7},
    '{32'h03, 8'h01, 8'h05, 8'h03, 4'h3},
    '{32'h25, 8'h00, 8'h80, 8'h7F, 4'h9},
    '{32'h26, 8'h00, 8'h01, 8'hFF, 4'h0},
    '{32'h08, 8'h0F, 8'hF0, 8'hFF, 4'h0},
    '{32'h09, 8'h5A, 8'h5A, 8'h00, 4'h4},
    '{32'h2C, 8'h33, 8'h00, 8'h00, 4'h4},
    '{32'h2F, 8'h00, 8'h81, 8'h03, 4'h0},
    '{32'h30, 8'h00, 8'h81, 8'hC0, 4'h0},
    '{32'h0A, 8'h55, 8'h00, 8'hAA, 4'h0}};
  asfl_top asfl_top_inst (.*);
  asfl_host asfl_host_inst (.*);
  initial begin
    forever #20 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = asfl_pkg::RESP_OKAY);
    logic [1:0] r;
    asfl_host_inst.wr(a, d, r);
    chk(r, er, "bresp");
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er = asfl_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    asfl_host_inst.rd(a, d, r);
    chk(r, er, "rresp");
    chk(d, ed, "rdata");
  endtask
  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(alu_flags_and_pointer_mode, 8'hF0, "flag reset");
    chk(working_register, 8'h00, "work reset");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    do_reset();
    get(asfl_pkg::ADDR_FILE, 32'h0);
    foreach (rows[i]) begin
      put(asfl_pkg::ADDR_WORK, {24'h0, rows[i].w});
      put(asfl_pkg::ADDR_FILE, {24'h0, rows[i].f});
      put(asfl_pkg::ADDR_FLAGS, 32'hF0);
      put(asfl_pkg::ADDR_CMD, rows[i].cmd);
      get(asfl_pkg::ADDR_RESULT, {24'h0, rows[i].res});
      chk(alu_flags_and_pointer_mode, {4'hF, rows[i].fl}, "flags");
      chk(working_register, rows[i].res, "work");
    end
    $display("test table done");
    put(asfl_pkg::ADDR_FLAGS, 32'hFB);
    put(asfl_pkg::ADDR_CMD, 32'h32B);
    chk(alu_flags_and_pointer_mode, 8'h0F, "clear flags");
    put(asfl_pkg::ADDR_FLAGS, 32'h30);
    put(asfl_pkg::ADDR_WORK, 32'h01);
    put(asfl_pkg::ADDR_CMD, 32'h300);
    chk(alu_flags_and_pointer_mode, 8'h30, "add to flags");
    put(asfl_pkg::ADDR_CMD, 32'h334);
    chk(alu_flags_and_pointer_mode, 8'h31, "bit set");
    put(asfl_pkg::ADDR_CMD, 32'h1333);
    chk(alu_flags_and_pointer_mode, 8'h21, "bit clear");
    put(asfl_pkg::ADDR_WORK, 32'h3C);
    put(asfl_pkg::ADDR_CMD, 32'h312);
    chk(alu_flags_and_pointer_mode, 8'h3C, "move from work");
    chk(working_register, 8'h3C, "work kept");
    get(asfl_pkg::ADDR_CMD, 32'h312);
    $display("test flag target done");
    put(asfl_pkg::ADDR_CMD, 32'h15, asfl_pkg::RESP_SLVERR);
    chk(alu_flags_and_pointer_mode, 8'h3C, "bad op no effect");
    get(8'h14, 32'h0, asfl_pkg::RESP_SLVERR);
    get(asfl_pkg::ADDR_FLAGS, 32'h3C);
    $display("test refusals done");
    do_reset();
    get(asfl_pkg::ADDR_FILE, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
